/* File: design/ofsl_defines.svh */
// Timing constants and reset values of the field switch latch
`ifndef OFSL_DEFINES_SVH
`define OFSL_DEFINES_SVH

// System clock rate in kHz (40 MHz)
`define OFSL_CLK_KHZ        40000
// Awake window length in microseconds
`define OFSL_AWAKE_US       50
// Sampling period length in milliseconds
`define OFSL_PERIOD_MS      50
// Awake window in clock cycles (longest time, rounded down)
`define OFSL_AWAKE_CYC      ((`OFSL_AWAKE_US * `OFSL_CLK_KHZ) / 1000)
// Sampling period in clock cycles
`define OFSL_PERIOD_CYC     (`OFSL_PERIOD_MS * `OFSL_CLK_KHZ)
// Primary output level after reset (inactive)
`define OFSL_OUT_RST        1'b1
// Bit positions of the synchronised front-end word
`define OFSL_B_S_OP         0
`define OFSL_B_N_OP         1
`define OFSL_B_S_REL        2
`define OFSL_B_N_REL        3
`define OFSL_B_SLOW         4
`define OFSL_SYNC_W         5

`endif

/* File: design/ofsl_pkg.sv */
// Types shared by the field switch latch modules
`include "ofsl_defines.svh"

package ofsl_pkg;

    // Sample cycle states, Gray coded along awake, capture, sleep
    typedef enum logic [1:0] {
        ST_AWAKE   = 2'b00,
        ST_CAPTURE = 2'b01,
        ST_SLEEP   = 2'b11
    } ofsl_state_t;

    // Register state of the latch module
    typedef struct packed {
        logic [`OFSL_SYNC_W-1:0] meta;
        logic [`OFSL_SYNC_W-1:0] sync;
        ofsl_state_t             state;
        logic                    primary;
        logic                    valid;
        logic                    skip;
        logic                    first_done;
        logic                    strobe;
    } ofsl_latch_st_t;

endpackage

/* File: design/ofsl_period_timer.sv */
// Free-running period timer producing the awake window
`timescale 1ns/1ps
`include "ofsl_defines.svh"

module ofsl_period_timer #(
    parameter int PERIOD_CYC = `OFSL_PERIOD_CYC,
    parameter int AWAKE_CYC  = `OFSL_AWAKE_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    output logic      awake,
    output logic      awake_fall
);

    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam logic [CW-1:0] LAST  = CW'(PERIOD_CYC - 1);
    localparam logic [CW-1:0] AWAKE = CW'(AWAKE_CYC);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          awake;
        logic          fall;
    } ofsl_tmr_st_t;

    ofsl_tmr_st_t st_ff;
    ofsl_tmr_st_t nxt_st;

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.cnt   = (st_ff.cnt == LAST) ? '0 : st_ff.cnt + CW'(1);
        nxt_st.awake = (nxt_st.cnt < AWAKE);
        nxt_st.fall  = st_ff.awake & ~nxt_st.awake;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_ff.cnt   <= '0;
            st_ff.awake <= 1'b1;
            st_ff.fall  <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign awake      = st_ff.awake;
    assign awake_fall = st_ff.fall;

endmodule

/* File: design/ofsl_field_latch.sv */
// Duty-cycled sample and hysteresis latch of the omnipolar field switch
`timescale 1ns/1ps
`include "ofsl_defines.svh"

module ofsl_field_latch #(
    parameter int PERIOD_CYC = `OFSL_PERIOD_CYC,
    parameter int AWAKE_CYC  = `OFSL_AWAKE_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic above_south_operate,
    input  wire logic below_north_operate,
    input  wire logic below_south_release,
    input  wire logic above_north_release,
    input  wire logic supply_slow_ramp,
    output logic      sense_enable,
    output logic      sample_strobe,
    output logic      output_valid,
    output logic      field_active_low_out,
    output logic      field_inverted_out
);

    ofsl_pkg::ofsl_latch_st_t st_ff;
    ofsl_pkg::ofsl_latch_st_t nxt_st;

    logic                    awake;
    logic                    awake_fall;
    logic [`OFSL_SYNC_W-1:0] pins;
    logic                    operate_hit;
    logic                    release_hit;
    logic                    decisive;
    logic                    take;

    // Awake window and sample instant
    ofsl_period_timer #(
        .PERIOD_CYC (PERIOD_CYC),
        .AWAKE_CYC  (AWAKE_CYC)
    ) u_timer (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .awake      (awake),
        .awake_fall (awake_fall)
    );

    always_comb begin
        pins                 = '0;
        pins[`OFSL_B_S_OP]   = above_south_operate;
        pins[`OFSL_B_N_OP]   = below_north_operate;
        pins[`OFSL_B_S_REL]  = below_south_release;
        pins[`OFSL_B_N_REL]  = above_north_release;
        pins[`OFSL_B_SLOW]   = supply_slow_ramp;
    end

    assign operate_hit = st_ff.sync[`OFSL_B_S_OP] | st_ff.sync[`OFSL_B_N_OP];
    assign release_hit = st_ff.sync[`OFSL_B_S_REL] & st_ff.sync[`OFSL_B_N_REL];
    assign decisive    = operate_hit | release_hit;
    assign take        = awake_fall && (st_ff.state == ofsl_pkg::ST_AWAKE);

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = pins;
        nxt_st.sync   = st_ff.meta;
        nxt_st.strobe = 1'b0;
        // Slow ramp seen before first sample
        if (!st_ff.first_done && st_ff.sync[`OFSL_B_SLOW]) begin
            nxt_st.skip = 1'b1;
        end
        case (st_ff.state)
            ofsl_pkg::ST_AWAKE: begin
                if (take) begin
                    nxt_st.state = ofsl_pkg::ST_CAPTURE;
                end
            end
            ofsl_pkg::ST_CAPTURE: begin
                nxt_st.state      = ofsl_pkg::ST_SLEEP;
                nxt_st.first_done = 1'b1;
                nxt_st.strobe     = 1'b1;
                if (!st_ff.first_done && st_ff.skip) begin
                    nxt_st.strobe = 1'b0;
                end else if (operate_hit) begin
                    nxt_st.primary = 1'b0;
                    nxt_st.valid   = 1'b1;
                end else if (release_hit) begin
                    nxt_st.primary = 1'b1;
                    nxt_st.valid   = 1'b1;
                end
            end
            ofsl_pkg::ST_SLEEP: begin
                if (awake) begin
                    nxt_st.state = ofsl_pkg::ST_AWAKE;
                end
            end
            default: begin
                nxt_st.state = ofsl_pkg::ST_AWAKE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_ff.meta       <= '0;
            st_ff.sync       <= '0;
            st_ff.state      <= ofsl_pkg::ST_AWAKE;
            st_ff.primary    <= `OFSL_OUT_RST;
            st_ff.valid      <= 1'b0;
            st_ff.skip       <= 1'b0;
            st_ff.first_done <= 1'b0;
            st_ff.strobe     <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sense_enable         = awake;
    assign sample_strobe        = st_ff.strobe;
    assign output_valid         = st_ff.valid;
    assign field_active_low_out = st_ff.primary;
    assign field_inverted_out   = ~st_ff.primary;

endmodule

/* File: dv/ofsl_latch_properties.sv */
// Assertion checker of the field switch latch
`timescale 1ns/1ps
module ofsl_chk #(
    parameter int PERIOD_CYC = 2000000,
    parameter int AWAKE_CYC  = 2000
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic above_south_operate,
    input wire logic below_north_operate,
    input wire logic below_south_release,
    input wire logic above_north_release,
    input wire logic supply_slow_ramp,
    input wire logic sense_enable,
    input wire logic sample_strobe,
    input wire logic output_valid,
    input wire logic field_active_low_out,
    input wire logic field_inverted_out
);
    int   since_rise;
    logic seen_rise;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            since_rise <= 0;
            seen_rise  <= 1'b0;
        end else begin
            since_rise <= $rose(sense_enable) ? 1 : since_rise + 1;
            seen_rise  <= seen_rise | $rose(sense_enable);
        end
    end
    sequence fall_s;
        $fell(sense_enable) && output_valid;
    endsequence
    sequence strobe_s;
        ##2 sample_strobe;
    endsequence
    sequence op_s;
        sample_strobe && ($past(above_south_operate, 3) || $past(below_north_operate, 3));
    endsequence
    sequence rel_s;
        sample_strobe && !$past(above_south_operate, 3) && !$past(below_north_operate, 3)
            && $past(below_south_release, 3) && $past(above_north_release, 3);
    endsequence
    sequence band_s;
        sample_strobe && !$past(above_south_operate, 3) && !$past(below_north_operate, 3)
            && !($past(below_south_release, 3) && $past(above_north_release, 3));
    endsequence
    compl_out_a: assert property (field_inverted_out == !field_active_low_out)
        else $error("Outputs not complementary");
    awake_len_a: assert property ($fell(sense_enable) && seen_rise |-> since_rise == AWAKE_CYC)
        else $error("Awake window length wrong");
    period_len_a: assert property ($rose(sense_enable) && seen_rise |-> since_rise == PERIOD_CYC)
        else $error("Sampling period wrong");
    sample_time_a: assert property (fall_s |-> strobe_s)
        else $error("No sample after awake fall");
    strobe_place_a: assert property (sample_strobe |-> $past(sense_enable, 3) && !$past(sense_enable, 2))
        else $error("Sample away from awake fall");
    sleep_hold_a: assert property (!sample_strobe |-> $stable(field_active_low_out) && $stable(output_valid))
        else $error("Output changed outside sample");
    operate_low_a: assert property (op_s |-> !field_active_low_out && output_valid)
        else $error("Operate sample not active");
    release_high_a: assert property (rel_s |-> field_active_low_out && output_valid)
        else $error("Release sample not inactive");
    band_hold_a: assert property (band_s |-> $stable(field_active_low_out))
        else $error("Band sample changed output");
endmodule
bind ofsl_field_latch ofsl_chk #(.PERIOD_CYC(PERIOD_CYC), .AWAKE_CYC(AWAKE_CYC)) u_chk (.*);

/* File: dv/ofsl_hall_model.sv */
// Behavioural Hall front end with its four comparators
`timescale 1ns/1ps
module ofsl_hall_model (
    input  wire logic       sys_clk,
    input  wire logic       sense_enable,
    input  wire logic [1:0] field_sel,
    output logic [3:0]      cmp
);
    logic       tog = 1'b0;
    logic [3:0] lvl;
    always @(posedge sys_clk) begin
        tog <= ~tog;
    end
    // Codes none, south, north, band; junk asleep
    always_comb begin
        case (field_sel)
            2'h0: lvl = 4'h3;
            2'h1: lvl = 4'h9;
            2'h2: lvl = 4'h6;
            default: lvl = 4'h1;
        endcase
        cmp = sense_enable ? lvl : {4{tog}};
    end
endmodule

/* File: dv/tb_top.sv */
// Testbench of the field switch latch
`timescale 1ns/1ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module tb_top;
    logic sys_clk = 1'b0, rst_b = 1'b0, slow = 1'b0, se, stb, vld, pri, inv;
    logic [1:0] fsel = 2'h0;
    logic [3:0] cmp;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (++cyc == 5000) begin error_cnt++; wrap_up(); end
    ofsl_hall_model fe (.sys_clk(sys_clk), .sense_enable(se), .field_sel(fsel), .cmp(cmp));
    ofsl_field_latch #(.PERIOD_CYC(100), .AWAKE_CYC(10)) uut (.sys_clk(sys_clk), .rst_b(rst_b),
        .above_south_operate(cmp[3]), .below_north_operate(cmp[2]), .below_south_release(cmp[1]),
        .above_north_release(cmp[0]), .supply_slow_ramp(slow), .sense_enable(se), .sample_strobe(stb),
        .output_valid(vld), .field_active_low_out(pri), .field_inverted_out(inv));
    task automatic do_reset(input logic s, input logic [1:0] f);
        @(negedge sys_clk) rst_b = 1'b0;
        slow = s;
        fsel = f;
        repeat (10) @(negedge sys_clk);
        rst_b = 1'b1;
        `CHK("sense", 1'b1, se)
        `CHK("valid", 1'b0, vld)
    endtask
    task automatic sample(input logic [1:0] f, input logic ep, input logic ev);
        int n = 0;
        fsel = f;
        while (stb !== 1'b1 && n < 250) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("strobe", 1'b1, stb)
        `CHK("primary", ep, pri)
        `CHK("inverted", ~ep, inv)
        `CHK("valid", ev, vld)
        @(negedge sys_clk);
    endtask
    task automatic slow_ramp();
        int n = 0;
        do_reset(1'b1, 2'h1);
        while (se !== 1'b0 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (2) @(negedge sys_clk);
        `CHK("dropped strobe", 1'b0, stb)
        `CHK("dropped primary", 1'b1, pri)
        sample(2'h1, 1'b0, 1'b1);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        do_reset(1'b0, 2'h3);
        sample(2'h3, 1'b1, 1'b0);
        sample(2'h1, 1'b0, 1'b1);
        sample(2'h3, 1'b0, 1'b1);
        sample(2'h0, 1'b1, 1'b1);
        sample(2'h2, 1'b0, 1'b1);
        sample(2'h3, 1'b0, 1'b1);
        sample(2'h0, 1'b1, 1'b1);
        slow_ramp();
        wrap_up();
    end
endmodule
